// [verilog/rtw_timer.sv]
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module rtw_timer
#(
    parameter int TBC_DIV = 1
)
(
    input  wire logic                       clock_in,
    input  wire logic                       rst_b_in,
    input  wire logic [rtw_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [rtw_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                       wr_in,
    input  wire logic                       rd_in,
    output logic      [rtw_pkg::DATA_W-1:0] rdata_out,
    output logic                            irq_out,
    output logic      [1:0]                 irq_priority_out,
    output logic      [15:0]                irq_vector_out,
    output logic                            system_reset_out,
    output logic                            wdt_reset_cause_out,
    output logic      [15:0]                reset_vector_out
);
    import rtw_pkg::*;

    localparam logic [TBC_CNT_W-1:0] TBC_LAST = TBC_CNT_W'(TBC_DIV - 1);

    logic [TBC_CNT_W-1:0]  tbc_cnt_ff;
    logic                  tbc_tick;
    logic [PRESCALE_W-1:0] pre_ff;
    logic [PRESCALE_W-1:0] tap;
    logic                  count_tick;
    logic [7:0]            count_ff;
    logic [7:0]            reload_ff;
    rtw_ctrl_t             ctrl_ff;
    rtw_irq_t              irq_ff;
    logic [7:0]            rdata_ff;
    logic                  sysrst_ff;
    logic                  counting;
    logic                  overflow;
    logic                  wr_count;
    logic                  wr_reload;
    logic                  wr_ctrl;
    logic                  wr_irq;
    logic                  code_start;
    logic                  code_good;
    logic [3:0]            expected;

    // The time base runs at the CPU clock divided by the front-stage ratio.
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in || tbc_tick)
            tbc_cnt_ff <= '0;
        else
            tbc_cnt_ff <= tbc_cnt_ff + 8'h01;
    end

    assign tbc_tick = (tbc_cnt_ff == TBC_LAST);

    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
            pre_ff <= '0;
        else if (tbc_tick)
            pre_ff <= pre_ff + 12'h001;
    end

    assign tap        = rtw_tap_mask(ctrl_ff.sel);
    assign count_tick = tbc_tick && ((pre_ff & tap) == tap);

    assign wr_count  = wr_in && (addr_in == COUNT_OFS);
    assign wr_reload = wr_in && (addr_in == RELOAD_OFS);
    assign wr_ctrl   = wr_in && (addr_in == CTRL_OFS);
    assign wr_irq    = wr_in && (addr_in == IRQ_OFS);

    // Only the low nibble of a service code is compared.
    assign expected   = ctrl_ff.next_code ? CODE_ALT : CODE_START;
    assign code_start = ctrl_ff.mode && !ctrl_ff.running
                        && (wdata_in[3:0] == CODE_START);
    assign code_good  = ctrl_ff.mode && ctrl_ff.running
                        && (wdata_in[3:0] == expected);

    assign counting = ctrl_ff.mode ? ctrl_ff.running : ctrl_ff.run;
    assign overflow = counting && count_tick && (count_ff == COUNT_MAX);

    // A software write wins over a coincident tick for the count, but a service in the
    // overflow cycle still lets the watchdog reset through.
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
            count_ff <= '0;
        else if (wr_count && !ctrl_ff.mode)
            count_ff <= wdata_in;
        else if (wr_count && code_good)
            count_ff <= reload_ff;
        else if (overflow)
            count_ff <= reload_ff;
        else if (counting && count_tick)
            count_ff <= count_ff + 8'h01;
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
            reload_ff <= '0;
        else if (!ctrl_ff.mode && wr_count)
            reload_ff <= wdata_in;
        else if (!ctrl_ff.mode && wr_reload)
            reload_ff <= wdata_in;
    end

    // In watchdog mode only the run bit still takes writes; it steers nothing.
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
            ctrl_ff <= CTRL_RESET;
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_ff.run <= wdata_in[RUN_BIT];
                if (!ctrl_ff.mode)
                begin
                    ctrl_ff.sel  <= wdata_in[SEL_LSB +: 3];
                    ctrl_ff.mode <= wdata_in[MODE_BIT];
                end
            end
            if (wr_count && code_start)
            begin
                ctrl_ff.running   <= 1'b1;
                ctrl_ff.next_code <= 1'b1;
            end
            else if (wr_count && code_good)
                ctrl_ff.next_code <= !ctrl_ff.next_code;
            ctrl_ff.fixed_one <= 1'b1;
        end
    end

    // The request set by an overflow wins over a clear in the same cycle.
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
            irq_ff <= IRQ_RESET;
        else
        begin
            if (wr_irq)
            begin
                irq_ff.enable   <= wdata_in[IRQ_EN_BIT];
                irq_ff.prio     <= wdata_in[IRQ_PRI_LSB +: 2];
                irq_ff.request  <= wdata_in[IRQ_REQ_BIT];
            end
            if (overflow && !ctrl_ff.mode)
                irq_ff.request <= 1'b1;
            irq_ff.unused <= '0;
        end
    end

    assign irq_out          = irq_ff.request && irq_ff.enable;
    assign irq_priority_out = irq_ff.prio;
    assign irq_vector_out   = OVF_VECTOR;

    // The reset request is a one-cycle pulse; the system reset logic then
    // asserts the reset input, which clears this block as well.
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
            sysrst_ff <= 1'b0;
        else
            sysrst_ff <= overflow && ctrl_ff.mode;
    end

    assign system_reset_out    = sysrst_ff;
    assign wdt_reset_cause_out = sysrst_ff;
    assign reset_vector_out    = WDT_VECTOR;

    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
            rdata_ff <= '0;
        else if (rd_in)
        begin
            unique case (addr_in)
                COUNT_OFS:  rdata_ff <= count_ff;
                RELOAD_OFS: rdata_ff <= reload_ff;
                CTRL_OFS:   rdata_ff <= ctrl_ff;
                IRQ_OFS:    rdata_ff <= irq_ff;
                default:    rdata_ff <= '0;
            endcase
        end
        else
            rdata_ff <= '0;
    end

    assign rdata_out = rdata_ff;

    a_mode_sticky: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        ctrl_ff.mode |=> ctrl_ff.mode)
        else $error("Watchdog mode was left without reset.");

    a_reload_copy: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (wr_count && !ctrl_ff.mode) |=> (reload_ff == count_ff))
        else $error("Count write did not copy into reload.");

    a_start_keeps: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (wr_count && code_start && !count_tick)
        |=> (ctrl_ff.running && count_ff == $past(count_ff)))
        else $error("Start code changed the count or did not start.");

    a_code_track: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (wr_count && code_start) |=> (ctrl_ff.next_code && ctrl_ff.running))
        else $error("Start code did not arm the alternate code.");

    a_service_load: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (wr_count && code_good)
        |=> (count_ff == $past(reload_ff)
             && ctrl_ff.next_code != $past(ctrl_ff.next_code)))
        else $error("Good service code did not reload and toggle.");

    a_bad_code: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (wr_count && ctrl_ff.running && wdata_in[3:0] != expected && !count_tick)
        |=> $stable(count_ff) && $stable(ctrl_ff.next_code))
        else $error("Wrong service code was not ignored.");

    a_period_lock: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        ctrl_ff.mode |=> ($stable(reload_ff) && $stable(ctrl_ff.sel)))
        else $error("Watchdog period changed in watchdog mode.");

    a_running_mode: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        ctrl_ff.running |-> ctrl_ff.mode)
        else $error("Watchdog running flag set outside watchdog mode.");

    a_wdt_reset: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (overflow && ctrl_ff.mode) |=> (system_reset_out && reset_vector_out == WDT_VECTOR))
        else $error("Watchdog overflow did not raise reset.");

    a_wdt_pulse: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        system_reset_out |=> !system_reset_out)
        else $error("Watchdog reset request lasted more than one cycle.");

    a_auto_no_reset: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !ctrl_ff.mode |=> !system_reset_out)
        else $error("System reset raised in auto-reload mode.");

    a_irq_only_auto: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (ctrl_ff.mode && !irq_ff.request && !wr_irq) |=> !irq_ff.request)
        else $error("Interrupt request set in watchdog mode.");

    a_irq_set: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (overflow && !ctrl_ff.mode) |=> irq_ff.request)
        else $error("Auto-reload overflow did not set the request.");

    a_ovf_reload: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (overflow && !wr_count) |=> (count_ff == $past(reload_ff)))
        else $error("Overflow did not load the reload value.");

    a_count_step: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (!ctrl_ff.mode && ctrl_ff.run && count_tick && count_ff != COUNT_MAX && !wr_count)
        |=> (count_ff == $past(count_ff) + 8'h01))
        else $error("Running counter did not step by one on a tick.");

    a_halt_holds: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (!ctrl_ff.mode && !ctrl_ff.run && !wr_count) |=> $stable(count_ff))
        else $error("Halted counter moved.");

    a_irq_gate: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (overflow && !ctrl_ff.mode && irq_ff.enable && !wr_irq) |=> irq_out)
        else $error("Enabled overflow request not passed on.");

    a_ctrl_reset: assert property (@(posedge clock_in)
        !rst_b_in |=> (ctrl_ff == CTRL_RESET))
        else $error("Control register not at reset value.");

endmodule : rtw_timer

// [verilog/rtw_pkg.sv]
// Operation
// - In auto-reload mode a write to the count register also loads the same value into the reload register.
// - The reload register supplies the value copied into the counter on each overflow.
// - Control bits 0 to 2 pick the count clock in both modes.
// - In auto-reload mode bit 3 high runs the counter, low halts it.
// - Writing bit 7 high enters watchdog mode; one byte sets mode and clock.
// - In watchdog mode the first low-nibble-3 count write starts counting, count unchanged.
// - Running watchdog takes codes C then 3 alternately; each reloads the counter.
// - The upper nibble of a service code is ignored; only the low nibble matters.
// - Read-only bit 6 shows whether code C or code 3 is expected next.
// - With the mode bit low the timer works in auto-reload mode.
// - Auto-reload counts up, requests an interrupt and reloads on each overflow.
// - Watchdog mode cannot be left until a system reset.
// - An unserviced running watchdog overflow raises a system reset.
// - The watchdog reset is flagged as its own cause with vector 0004.
// - From a load of R, overflow follows after 256 minus R count ticks.
// - Only auto-reload overflows and software writes of bit 0 set the interrupt request flag.
// - An enable flag gates the overflow request to the processor.
// - Two priority bits give the overflow interrupt one of four levels.
// - The overflow interrupt uses vector address 0042.
// - Clock codes 000 to 111 divide the time base by 8 up to 4096.
// - Read-only bit 5 reads one while the watchdog is counting.
// - In watchdog mode writes that would change the period are ignored.
// - A system reset returns control to 10H: auto-reload mode, halted.
package rtw_pkg;

    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;
    localparam int          PRESCALE_W    = 12;
    localparam int          TBC_CNT_W     = 8;

    localparam logic [7:0]  COUNT_OFS     = 8'h7C;
    localparam logic [7:0]  RELOAD_OFS    = 8'h7D;
    localparam logic [7:0]  CTRL_OFS      = 8'h7E;
    localparam logic [7:0]  IRQ_OFS       = 8'h7F;

    localparam logic [7:0]  CTRL_RESET    = 8'h10;
    localparam int          SEL_LSB       = 0;
    localparam int          RUN_BIT       = 3;
    localparam int          MODE_BIT      = 7;

    localparam int          IRQ_REQ_BIT   = 0;
    localparam int          IRQ_EN_BIT    = 1;
    localparam int          IRQ_PRI_LSB   = 2;
    localparam logic [7:0]  IRQ_RESET     = 8'h00;

    localparam logic [3:0]  CODE_START    = 4'h3;
    localparam logic [3:0]  CODE_ALT      = 4'hC;
    localparam logic [7:0]  COUNT_MAX     = 8'hFF;

    localparam logic [15:0] WDT_VECTOR    = 16'h0004;
    localparam logic [15:0] OVF_VECTOR    = 16'h0042;

    typedef struct packed
    {
        logic       mode;
        logic       next_code;
        logic       running;
        logic       fixed_one;
        logic       run;
        logic [2:0] sel;
    } rtw_ctrl_t;

    typedef struct packed
    {
        logic [3:0] unused;
        logic [1:0] prio;
        logic       enable;
        logic       request;
    } rtw_irq_t;

    // Mask of prescaler bits that must all be set for one count tick.
    function automatic logic [PRESCALE_W-1:0] rtw_tap_mask(input logic [2:0] sel);
        logic [PRESCALE_W-1:0] m;
        m = 12'h007;
        unique case (sel)
            3'h0: m = 12'h007;
            3'h1: m = 12'h00F;
            3'h2: m = 12'h01F;
            3'h3: m = 12'h03F;
            3'h4: m = 12'h07F;
            3'h5: m = 12'h0FF;
            3'h6: m = 12'h3FF;
            3'h7: m = 12'hFFF;
        endcase
        return m;
    endfunction : rtw_tap_mask

endpackage : rtw_pkg

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import rtw_pkg::*;

    typedef struct
    {
        logic [7:0]  rld;
        logic [2:0]  sel;
        logic [15:0] per;
    } rtw_row_t;

    logic        clock_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [7:0]  wdata_in = 8'h00;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [7:0]  rdata_out;
    logic        irq_out;
    logic [1:0]  irq_priority_out;
    logic [15:0] irq_vector_out;
    logic        system_reset_out;
    logic        wdt_reset_cause_out;
    logic [15:0] reset_vector_out;
    int          fail_count = 0;
    int          checks = 0;
    int          cyc = 0;
    int          rst_pulses = 0;
    int          n;
    int          t0;
    logic [7:0]  v1;
    logic [7:0]  v2;
    rtw_row_t    rows [10] = '{'{8'hFF, 3'h0, 16'h0008}, '{8'hFF, 3'h1, 16'h0010},
                               '{8'hFF, 3'h2, 16'h0020}, '{8'hFF, 3'h3, 16'h0040},
                               '{8'hFF, 3'h4, 16'h0080}, '{8'hFF, 3'h5, 16'h0100},
                               '{8'hFF, 3'h6, 16'h0400}, '{8'hFF, 3'h7, 16'h1000},
                               '{8'hFC, 3'h0, 16'h0020}, '{8'h00, 3'h0, 16'h0800}};

    rtw_timer #(.TBC_DIV(1)) i_rtw_timer
    (
        .clock_in            (clock_in),
        .rst_b_in            (rst_b_in),
        .addr_in             (addr_in),
        .wdata_in            (wdata_in),
        .wr_in               (wr_in),
        .rd_in               (rd_in),
        .rdata_out           (rdata_out),
        .irq_out             (irq_out),
        .irq_priority_out    (irq_priority_out),
        .irq_vector_out      (irq_vector_out),
        .system_reset_out    (system_reset_out),
        .wdt_reset_cause_out (wdt_reset_cause_out),
        .reset_vector_out    (reset_vector_out)
    );

    always #2 clock_in = ~clock_in;

    always @(posedge clock_in)
    begin
        cyc++;
        if (system_reset_out === 1'b1)
            rst_pulses++;
    end

    task automatic final_report;
        if (fail_count == 0 && checks > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clock_in);
        wr_in    <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe, so it is taken there.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clock_in);
        rd_in   <= 1'b0;
        #1;
        v = rdata_out;
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] v;
        rd(a, v);
        chk(nm, {8'h00, e}, {8'h00, v});
    endtask : rdc

    task automatic wait_irq();
        #1;
        n = 0;
        while (irq_out !== 1'b1 && n < 9000)
        begin
            @(posedge clock_in);
            #1;
            n++;
        end
    endtask : wait_irq

    initial
    begin
        repeat (60000) @(posedge clock_in);
        fail_count++;
        final_report();
    end

    initial
    begin
        repeat (3) @(posedge clock_in);
        rst_b_in <= 1'b1;
        rdc(CTRL_OFS, CTRL_RESET, "ctrl_reset");
        rdc(IRQ_OFS, IRQ_RESET, "irq_reset");
        rdc(8'h00, 8'h00, "unmapped");
        chk("irq_vector", OVF_VECTOR, irq_vector_out);
        wr(COUNT_OFS, 8'h5A);
        rdc(COUNT_OFS, 8'h5A, "count");
        rdc(RELOAD_OFS, 8'h5A, "reload_copy");
        wr(RELOAD_OFS, 8'h33);
        rdc(RELOAD_OFS, 8'h33, "reload");
        rdc(COUNT_OFS, 8'h5A, "count_halted");
        wr(CTRL_OFS, 8'h77);
        rdc(CTRL_OFS, 8'h17, "ctrl_fixed_bits");
        // Overflow with the enable low: request set but not passed on.
        wr(COUNT_OFS, 8'hFF);
        wr(CTRL_OFS, 8'h08);
        repeat (20) @(posedge clock_in);
        #1;
        chk("irq_masked", 16'h0000, {15'h0000, irq_out});
        rdc(IRQ_OFS, 8'h01, "irq_request");
        wr(IRQ_OFS, 8'h0F);
        #1;
        chk("irq_enabled", 16'h0001, {15'h0000, irq_out});
        chk("priority", 16'h0003, {14'h0000, irq_priority_out});
        wr(CTRL_OFS, 8'h00);
        wr(IRQ_OFS, 8'h00);
        rd(COUNT_OFS, v1);
        repeat (40) @(posedge clock_in);
        rd(COUNT_OFS, v2);
        chk("halt", {8'h00, v1}, {8'h00, v2});
        foreach (rows[i])
        begin
            wr(COUNT_OFS, rows[i].rld);
            wr(IRQ_OFS, 8'h02);
            wr(CTRL_OFS, {5'h01, rows[i].sel});
            wait_irq();
            t0 = cyc;
            wr(IRQ_OFS, 8'h02);
            wait_irq();
            chk("period", rows[i].per, 16'(cyc - t0));
            wr(CTRL_OFS, 8'h00);
            wr(IRQ_OFS, 8'h02);
        end
        wr(COUNT_OFS, 8'hF0);
        wr(CTRL_OFS, 8'h80);
        rdc(CTRL_OFS, 8'h90, "wdt_idle");
        wr(RELOAD_OFS, 8'h11);
        rdc(RELOAD_OFS, 8'hF0, "wdt_reload_locked");
        wr(CTRL_OFS, 8'h07);
        rdc(CTRL_OFS, 8'h90, "wdt_mode_locked");
        wr(COUNT_OFS, 8'hA3);
        rdc(CTRL_OFS, 8'hF0, "wdt_started");
        wr(COUNT_OFS, 8'h73);
        rdc(CTRL_OFS, 8'hF0, "wdt_wrong_code");
        wr(COUNT_OFS, 8'h5C);
        rdc(CTRL_OFS, 8'hB0, "wdt_next_code");
        repeat (6)
        begin
            repeat (40) @(posedge clock_in);
            wr(COUNT_OFS, 8'hE3);
            repeat (40) @(posedge clock_in);
            wr(COUNT_OFS, 8'h2C);
        end
        chk("wdt_serviced", 16'h0000, 16'(rst_pulses));
        n = 0;
        while (system_reset_out !== 1'b1 && n < 300)
        begin
            @(posedge clock_in);
            #1;
            n++;
        end
        // Sixteen ticks of eight cycles, less up to seven cycles of prescaler phase.
        chk("wdt_time", 16'h0001, {15'h0000, n >= 121 && n <= 128});
        chk("wdt_cause", 16'h0001, {15'h0000, wdt_reset_cause_out});
        chk("reset_vector", WDT_VECTOR, reset_vector_out);
        chk("wdt_no_irq", 16'h0000, {15'h0000, irq_out});
        @(posedge clock_in);
        rst_b_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        rst_b_in <= 1'b1;
        rdc(CTRL_OFS, CTRL_RESET, "ctrl_after_reset");
        final_report();
    end

endmodule : testbench
